// File: logic/cwt_pkg.sv
// Constants shared by the program health watchdog files
package cwt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: word index, byte address is four times the index
  localparam int CWT_ADDR_W = 18;
  localparam logic [15:0] CWT_IDX_FIRST_CONFIGURATION_REGISTER = 16'h001e;
  localparam logic [15:0] CWT_IDX_CONFIG2 = 16'h001f;
  localparam logic [15:0] CWT_IDX_CAUSE = 16'h0020;
  localparam logic [15:0] CWT_IDX_CLEAR = 16'hffff;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CWT_CFG1_DISABLE_BIT = 0;
  localparam int CWT_CFG1_RATE_BIT = 7;
  localparam int CWT_CFG2_RESET_PIN_FUNCTION_ENABLE_BIT = 0;
  localparam int CWT_CAUSE_WDOG_BIT = 0;
  localparam int CWT_CAUSE_CNT_LSB = 8;
  localparam int CWT_CAUSE_DIS_BIT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic CWT_DISABLE_RST = 1'b0;
  localparam logic CWT_RATE_RST = 1'b0;
  localparam logic CWT_RESET_PIN_FUNCTION_ENABLE_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and timing, in oscillator clock cycles
  localparam int CWT_PRESC_W = 12;
  localparam int CWT_WDOG_W = 6;
  localparam int CWT_SHORT_TAP_W = 7;
  localparam int CWT_LONG_TIMEOUT_CYC = 262128;
  localparam int CWT_SHORT_TIMEOUT_CYC = 8176;
  localparam int CWT_RST_PIN_CYC = 32;
  localparam int CWT_POR_CLEAR_CYC = 4096;
  localparam logic [CWT_WDOG_W-1:0] CWT_WDOG_MAX = 6'h3f;
  localparam logic [CWT_PRESC_W-1:0] CWT_LONG_MATCH =
    CWT_PRESC_W'(CWT_LONG_TIMEOUT_CYC - 63 * 4096);
  localparam logic [CWT_SHORT_TAP_W-1:0] CWT_SHORT_MATCH =
    CWT_SHORT_TAP_W'(CWT_SHORT_TIMEOUT_CYC - 63 * 128);

endpackage

// File: logic/cwt_prescaler.sv
// Twelve-bit prescaler counter feeding the watchdog
`timescale 1ns/1ps
module cwt_prescaler
  import cwt_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic service_i,
  output logic [CWT_PRESC_W-1:0] count_o
);

  typedef struct packed {
    logic [CWT_PRESC_W-1:0] cnt;
  } cwt_presc_s;

  cwt_presc_s s;
  cwt_presc_s next_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    if (clear_i)
    begin
      next_s.cnt = '0;
    end
    else
    begin
      if (run_i)
      begin
        next_s.cnt = s.cnt + 12'h001;
      end
      // Low four stages survive a service write
      if (service_i)
      begin
        next_s.cnt[CWT_PRESC_W-1:4] = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count_o = s.cnt;

endmodule

// File: logic/cwt_pin_driver.sv
// Open-drain reset pin driver, holds the pin low for a fixed count
`timescale 1ns/1ps
module cwt_pin_driver
  import cwt_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  output logic pin_o,
  output logic pin_oe_o
);

  typedef enum logic {
    CWT_PIN_IDLE,
    CWT_PIN_DRIVE
  } cwt_pin_e;

  typedef struct packed {
    cwt_pin_e state;
    logic [5:0] cnt;
  } cwt_pin_s;

  localparam logic [5:0] CWT_PIN_LAST = 6'(CWT_RST_PIN_CYC - 1);

  cwt_pin_s s;
  cwt_pin_s next_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    case (s.state)
      CWT_PIN_IDLE:
      begin
        if (start_i)
        begin
          next_s.state = CWT_PIN_DRIVE;
          next_s.cnt = '0;
        end
      end
      CWT_PIN_DRIVE:
      begin
        if (s.cnt == CWT_PIN_LAST)
        begin
          next_s.state = CWT_PIN_IDLE;
        end
        else
        begin
          next_s.cnt = s.cnt + 6'h01;
        end
      end
      default:
      begin
        next_s.state = CWT_PIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s <= '{state: CWT_PIN_IDLE, cnt: 6'h00};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Pin is only ever pulled low; release lets the pullup win
  assign pin_o = 1'b0;
  assign pin_oe_o = (s.state == CWT_PIN_DRIVE);

endmodule

// File: logic/cwt_top.sv
// Program health watchdog with APB register access
// Behaviour
// - Six-bit counter clocked from twelve-bit prescaler
// - Overflow raises reset after selected cycle count
// - Any write to clear address restarts timeout
// - Clear address reads reset vector low byte
// - Reset pin low 32 cycles when enabled
// - Watchdog reset sets cause flag
// - Stop instruction clears prescaler
// - Prescaler cleared 4096 cycles after power-up
// - Internal reset clears prescaler and counter
// - Disable and rate follow configuration bits
// - No interrupt request, only reset
// - Monitor test voltage disables watchdog
// - Watchdog keeps counting in wait mode
// - Stop mode gates clock, clears prescaler
// - Break in monitor mode may disable
// - Disable bit one disables, reset clears it
// - Rate bit one short, zero long
`timescale 1ns/1ps
module cwt_top
  import cwt_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CWT_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] reset_vector_lo_i,
  input wire logic internal_reset_i,
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  input wire logic monitor_test_voltage_i,
  input wire logic break_active_i,
  input wire logic break_watchdog_disable_i,
  output logic reset_request_o,
  output logic reset_pin_o,
  output logic reset_pin_oe_o
);

  typedef struct packed {
    logic [1:0] mon_sync;
    logic watchdog_disable_bit;
    logic watchdog_rate_select;
    logic cfg1_locked;
    logic reset_pin_function_enable;
    logic cfg2_locked;
    logic cause_wdog;
    logic [CWT_WDOG_W-1:0] wdog;
    logic [12:0] por_cnt;
    logic por_done;
    logic req;
    logic [31:0] prdata;
  } cwt_top_s;

  localparam logic [12:0] CWT_POR_LAST = 13'(CWT_POR_CLEAR_CYC - 1);

  cwt_top_s s;
  cwt_top_s next_s;

  logic [CWT_PRESC_W-1:0] presc;
  logic [15:0] idx;
  logic hit_cfg1;
  logic hit_cfg2;
  logic hit_cause;
  logic hit_clear;
  logic hit;
  logic setup;
  logic wr;
  logic cfg1_wr;
  logic cfg2_wr;
  logic cause_wr;
  logic service;
  logic por_clear;
  logic monitor;
  logic cfg_off;
  logic mon_off;
  logic brk_off;
  logic disabled;
  logic running;
  logic short_tick;
  logic long_tick;
  logic short_match;
  logic long_match;
  logic tick;
  logic match;
  logic overflow;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states, so access phase lasts one cycle
  assign idx = paddr_i[CWT_ADDR_W-1:2];
  assign hit_cfg1 = (idx == CWT_IDX_FIRST_CONFIGURATION_REGISTER);
  assign hit_cfg2 = (idx == CWT_IDX_CONFIG2);
  assign hit_cause = (idx == CWT_IDX_CAUSE);
  assign hit_clear = (idx == CWT_IDX_CLEAR);
  assign hit = hit_cfg1 || hit_cfg2 || hit_cause || hit_clear;
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i && hit;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;
  // Clear address ignores strobes: any write at all must service
  assign service = wr && hit_clear;
  // Configuration and cause need the low byte lane
  assign cfg1_wr = wr && pstrb_i[0] && hit_cfg1;
  assign cfg2_wr = wr && pstrb_i[0] && hit_cfg2;
  assign cause_wr = wr && pstrb_i[0] && hit_cause;

  ////////////////////////////////////////////////////////////////////////////
  // Enable and timebase
  assign monitor = s.mon_sync[1];
  assign cfg_off = s.watchdog_disable_bit;
  assign mon_off = monitor;
  // Break disable only applies with the test voltage present
  assign brk_off = break_active_i && monitor &&
                   break_watchdog_disable_i;
  assign disabled = cfg_off || mon_off || brk_off;
  // Wait mode deliberately does not appear here
  assign running = !stop_mode_i && !disabled;
  // One-shot: later internal resets must not start this power-up clear again
  assign por_clear = !s.por_done && (s.por_cnt == CWT_POR_LAST);

  // Short rate ticks on the seventh stage, long on the full carry
  always_comb
  begin
    short_tick = (presc[CWT_SHORT_TAP_W-1:0] == '1);
    long_tick = (presc == '1);
    short_match = (presc[CWT_SHORT_TAP_W-1:0] == CWT_SHORT_MATCH);
    long_match = (presc == CWT_LONG_MATCH);
    if (s.watchdog_rate_select)
    begin
      tick = short_tick;
      match = short_match;
    end
    else
    begin
      tick = long_tick;
      match = long_match;
    end
  end

  // Service and internal reset win over a same-cycle overflow
  assign overflow = running && !service && !internal_reset_i &&
                    (s.wdog == CWT_WDOG_MAX) && match;

  ////////////////////////////////////////////////////////////////////////////
  // Read word, taken into prdata in the setup cycle
  always_comb
  begin
    rd_word = 32'h00000000;
    case (idx)
      CWT_IDX_FIRST_CONFIGURATION_REGISTER:
      begin
        rd_word[CWT_CFG1_DISABLE_BIT] = s.watchdog_disable_bit;
        rd_word[CWT_CFG1_RATE_BIT] = s.watchdog_rate_select;
      end
      CWT_IDX_CONFIG2:
      begin
        rd_word[CWT_CFG2_RESET_PIN_FUNCTION_ENABLE_BIT] = s.reset_pin_function_enable;
      end
      CWT_IDX_CAUSE:
      begin
        rd_word[CWT_CAUSE_WDOG_BIT] = s.cause_wdog;
        rd_word[CWT_CAUSE_CNT_LSB +: CWT_WDOG_W] = s.wdog;
        rd_word[CWT_CAUSE_DIS_BIT] = disabled;
      end
      CWT_IDX_CLEAR:
      begin
        // Overlaps the vector, so no watchdog state leaks out
        rd_word[7:0] = reset_vector_lo_i;
      end
      default:
      begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  cwt_prescaler u_prescaler (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .run_i(!stop_mode_i),
    .clear_i(stop_mode_i || por_clear || internal_reset_i),
    .service_i(service),
    .count_o(presc)
  );

  cwt_pin_driver u_pin_driver (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(overflow && s.reset_pin_function_enable),
    .pin_o(reset_pin_o),
    .pin_oe_o(reset_pin_oe_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s = s;
    next_s.mon_sync = {s.mon_sync[0], monitor_test_voltage_i};
    next_s.req = overflow;

    if (!s.por_done)
    begin
      next_s.por_cnt = s.por_cnt + 13'h0001;
      if (por_clear)
      begin
        next_s.por_done = 1'b1;
      end
    end

    // Watchdog counter
    if (internal_reset_i || service || disabled)
    begin
      next_s.wdog = '0;
    end
    else if (running && tick)
    begin
      next_s.wdog = s.wdog + 6'h01;
    end

    // Configuration, writable once after each reset
    if (cfg1_wr && !s.cfg1_locked)
    begin
      next_s.watchdog_disable_bit = pwdata_i[CWT_CFG1_DISABLE_BIT];
      next_s.watchdog_rate_select = pwdata_i[CWT_CFG1_RATE_BIT];
      next_s.cfg1_locked = 1'b1;
    end
    if (cfg2_wr && !s.cfg2_locked)
    begin
      next_s.reset_pin_function_enable = pwdata_i[CWT_CFG2_RESET_PIN_FUNCTION_ENABLE_BIT];
      next_s.cfg2_locked = 1'b1;
    end

    // Cause flag: write one clears, a new overflow wins
    if (cause_wr && pwdata_i[CWT_CAUSE_WDOG_BIT])
    begin
      next_s.cause_wdog = 1'b0;
    end
    if (overflow)
    begin
      next_s.cause_wdog = 1'b1;
    end

    // Internal reset leaves the pin enable and cause flag alone
    if (internal_reset_i)
    begin
      next_s.watchdog_disable_bit = CWT_DISABLE_RST;
      next_s.watchdog_rate_select = CWT_RATE_RST;
      next_s.cfg1_locked = 1'b0;
      next_s.cfg2_locked = 1'b0;
    end

    // Read data captured in setup so it is stable in the access phase
    if (setup)
    begin
      next_s.prdata = rd_word;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // Pin enable and cause flag are reset only here, at power-on
      s.mon_sync <= 2'b00;
      s.watchdog_disable_bit <= CWT_DISABLE_RST;
      s.watchdog_rate_select <= CWT_RATE_RST;
      s.cfg1_locked <= 1'b0;
      s.reset_pin_function_enable <= CWT_RESET_PIN_FUNCTION_ENABLE_RST;
      s.cfg2_locked <= 1'b0;
      s.cause_wdog <= 1'b0;
      s.wdog <= 6'h00;
      s.por_cnt <= 13'h0000;
      s.por_done <= 1'b0;
      s.req <= 1'b0;
      s.prdata <= 32'h00000000;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  // Reset request is the only action; no interrupt line exists
  assign reset_request_o = s.req;

endmodule

// File: bench/cwt_chk_asserts.sv
// Concurrent checks on the watchdog top ports
`timescale 1ns/1ps
module cwt_chk
  import cwt_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [CWT_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic [7:0] reset_vector_lo_i,
  input wire logic internal_reset_i,
  input wire logic stop_mode_i,
  input wire logic monitor_test_voltage_i,
  input wire logic reset_request_o,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o
);
  // Service leaves up to 15 low prescaler counts behind
  localparam int QMIN = CWT_SHORT_TIMEOUT_CYC - 16;
  int qcnt;
  int ocnt;
  logic acc;
  assign acc = psel_i && penable_i && paddr_i[17:2] == CWT_IDX_CLEAR;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      qcnt <= 0;
      ocnt <= 0;
    end
    else
    begin
      qcnt <= (acc && pwrite_i || internal_reset_i) ? 0 : qcnt + 1;
      ocnt <= reset_pin_oe_o ? ocnt + 1 : 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_drop;
    ##1 !reset_request_o;
  endsequence
  sequence s_mon;
    monitor_test_voltage_i [*5];
  endsequence
  property p_pulse;
    reset_request_o |-> s_drop;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("request too long");
  property p_start;
    $rose(reset_pin_oe_o) |-> reset_request_o && !reset_pin_o;
  endproperty
  a_start: assert property (p_start)
    else $error("pin drive start");
  property p_len;
    $fell(reset_pin_oe_o) |-> ocnt == CWT_RST_PIN_CYC;
  endproperty
  a_len: assert property (p_len)
    else $error("pin drive length");
  property p_vec;
    acc && !pwrite_i |-> prdata_o == {24'h0, $past(reset_vector_lo_i)};
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector byte read");
  property p_quiet;
    $rose(reset_request_o) |-> qcnt >= QMIN;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("request too early");
  property p_mon;
    s_mon |-> !reset_request_o;
  endproperty
  a_mon: assert property (p_mon)
    else $error("request in monitor");
  property p_stop;
    stop_mode_i |=> !reset_request_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("request in stop");
  property p_irst;
    internal_reset_i |=> !reset_request_o;
  endproperty
  a_irst: assert property (p_irst)
    else $error("request after reset");
endmodule
bind cwt_top cwt_chk u_cwt_chk (.clk_i, .resetn_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .reset_vector_lo_i, .internal_reset_i,
  .stop_mode_i, .monitor_test_voltage_i, .reset_request_o, .reset_pin_o,
  .reset_pin_oe_o);

// File: bench/cwt_sysrst_model.sv
// System reset controller answering watchdog requests
`timescale 1ns/1ps
module cwt_sysrst_model
#(
  parameter int DELAY = 3
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  output logic irst_o
);
  int cnt;
  // Late answer, held four cycles so every counter sees it
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt <= 0;
    else if (req_i)
      cnt <= 1;
    else if (cnt != 0)
      cnt <= (cnt == DELAY + 4) ? 0 : cnt + 1;
  end
  assign irst_o = cnt > DELAY;
endmodule

// File: bench/cwt_top_tb_top.sv
// Self-checking bench for the watchdog top
`timescale 1ns/1ps
module cwt_top_tb_top
  import cwt_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [15:0] idx;
    logic [31:0] d;
    logic [31:0] r;
    logic e;
  } cwt_row_s;
  logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [CWT_ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, r;
  logic pready_o, pslverr_o, irst, req, pin, oe, e;
  logic stop = 0, wt = 0, mon = 0, irst_b = 0;
  int err_total = 0, samples_checked = 0, cyc = 0, n;
  cwt_row_s rows [7];
  cwt_top u_cwt_top (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pstrb_i(4'hf), .prdata_o, .pready_o, .pslverr_o,
    .reset_vector_lo_i(8'h5a), .internal_reset_i(irst | irst_b),
    .stop_mode_i(stop), .wait_mode_i(wt), .monitor_test_voltage_i(mon),
    .break_active_i(mon), .break_watchdog_disable_i(mon),
    .reset_request_o(req), .reset_pin_o(pin), .reset_pin_oe_o(oe));
  cwt_sysrst_model u_cwt_sysrst_model (.clk_i, .resetn_i, .req_i(req),
    .irst_o(irst));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] idx,
    input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= {idx, 2'h0};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    @(posedge clk_i);
    while (pready_o !== 1'h1)
      @(posedge clk_i);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  // Counts whole cycles so a missing request shows as n == max
  task automatic wreq(input int max);
    n = 0;
    while (req !== 1'h1 && n < max)
    begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask
  initial
  begin
    rows[0] = {1'h0, CWT_IDX_CLEAR, 32'h0, 32'h5a, 1'h0};
    rows[1] = {1'h0, CWT_IDX_FIRST_CONFIGURATION_REGISTER, 32'h0, 32'h0, 1'h0};
    rows[2] = {1'h0, 16'h0100, 32'h0, 32'h0, 1'h1};
    rows[3] = {1'h1, CWT_IDX_FIRST_CONFIGURATION_REGISTER, 32'h80, 32'h0, 1'h0};
    rows[4] = {1'h1, CWT_IDX_CONFIG2, 32'h1, 32'h0, 1'h0};
    rows[5] = {1'h1, CWT_IDX_FIRST_CONFIGURATION_REGISTER, 32'h1, 32'h0, 1'h0};
    rows[6] = {1'h0, CWT_IDX_FIRST_CONFIGURATION_REGISTER, 32'h0, 32'h80, 1'h0};
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'h1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].idx, rows[i].d);
      if (!rows[i].w)
        chk(r, rows[i].r);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    stop <= 1'h1;
    wreq(9000);
    chk(n, 9000);
    stop <= 1'h0;
    mon <= 1'h1;
    wreq(9000);
    chk(n, 9000);
    mon <= 1'h0;
    wt <= 1'h1;
    apb(1'h1, CWT_IDX_CLEAR, 32'h0);
    wreq(9000);
    chk(32'(n >= 8160 && n <= 8177), 32'h1);
    chk({31'h0, oe}, 32'h1);
    wt <= 1'h0;
    repeat (40) @(posedge clk_i);
    chk({31'h0, oe}, 32'h0);
    apb(1'h0, CWT_IDX_CAUSE, 32'h0);
    chk(r, 32'h1);
    apb(1'h0, CWT_IDX_FIRST_CONFIGURATION_REGISTER, 32'h0);
    chk(r, 32'h0);
    apb(1'h1, CWT_IDX_FIRST_CONFIGURATION_REGISTER, 32'h80);
    repeat (3)
    begin
      apb(1'h1, CWT_IDX_CLEAR, 32'h0);
      wreq(4500);
      chk(n, 4500);
    end
    irst_b <= 1'h1;
    @(posedge clk_i);
    irst_b <= 1'h0;
    apb(1'h1, CWT_IDX_FIRST_CONFIGURATION_REGISTER, 32'h81);
    apb(1'h0, CWT_IDX_CAUSE, 32'h0);
    chk(r, 32'h10001);
    wreq(9000);
    chk(n, 9000);
    summarize();
  end
endmodule
